// *** rtl/ssp_dev.sv ***
// smbus slave register port of the monitor device
// How it works
// [R1] 7-bit address, 8-bit register, 8-bit data
// [R2] bytes shift most significant bit first
// [R3] write: addr, reg, data, each acknowledged
// [R4] read: addr, reg, restart, addr read, data
// [R5] repeated start marks a read access
// [R6] registers change only on complete sequences
// [R7] foreign address or bad protocol: stay silent
// [R8] straps pick one of three addresses
// [R9] strapped address latched on first complete write made with address enable low
// [R10] undefined registers read zero, ignore writes
// [R11] general call never acknowledged
// [R12] clock low over 25 ms aborts
// [R13] never drive the clock line
// [R14] start then stop resets to idle
// [R15] alert address acked if enabled and pending
// [R16] alert answer carries own address
// [R17] alert answer clears interrupt enable
// [R18] alert answered without pin routing too
// [R19] alert output routable to two pins
// [R20] start bit at 0x40 begins monitoring
// [R21] reset loads defaults into registers
// [R22] limit events gathered into status
// [R23] host ack after data: release, wait
//
// The Wishbone interface to the registers was left to the implementer.
`include "ssp_map.svh"
`timescale 1ns/1ps
module ssp_dev (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  ssp_if.dev              bus,
  input  wire logic       addr_enable_n_i,
  input  wire logic       addr_select_i,
  input  wire logic [7:0] event_i,
  input  wire logic [7:0] group_enable_i,
  input  wire logic [1:0] alert_route_i,
  output logic            monitor_start_o,
  output logic [7:0]      status_o,
  output logic            fan_drive2_pin_oe_n_o,
  output logic            fan_speed_in3_pin_oe_n_o
);
  localparam int TO_CYC = `SSP_TIMEOUT_CYC;
  logic [2:0] scl_s, sda_s;
  logic       scl_f, sda_f, scl_q, sda_q;
  ssp_pkg::ssp_slv_t st;
  logic [7:0] sh;
  logic [2:0] bitc;
  logic [1:0] byten;
  logic       rd, ara, had_reg, fresh;
  logic [7:0] reg_ptr, wdata;
  logic [7:0] start_reg, special_reg;
  logic [6:0] my_addr;
  logic       addr_locked;
  logic [1:0] aen_s, asel_s;
  logic [21:0] to_cnt;
  logic       timeout;
  always_ff @(posedge clk_i) begin
    scl_s <= {scl_s[1:0], bus.scl};
    sda_s <= {sda_s[1:0], bus.sda};
    aen_s <= {aen_s[0], addr_enable_n_i};
    asel_s <= {asel_s[0], addr_select_i};
  end
  assign scl_f = scl_s[1];
  assign sda_f = sda_s[1];
  assign scl_q = scl_s[2];
  assign sda_q = sda_s[2];
  wire scl_rise = scl_f & ~scl_q;
  wire scl_fall = ~scl_f & scl_q;
  wire start_c  = scl_f & scl_q & sda_q & ~sda_f;
  wire stop_c   = scl_f & scl_q & ~sda_q & sda_f;
  wire pending  = |(status_o & group_enable_i); // R18
  wire alert_on = special_reg[`SSP_ALERT_IRQ_ENABLE_BIT] & pending;
  // straps are pins, so only their synchronised copies are read
  wire [6:0] strap_addr = aen_s[1] ? `SSP_ADDR_DEFAULT :
                          (asel_s[1] ? `SSP_ADDR_SEL1 : `SSP_ADDR_SEL0); // R8
  wire [6:0] cur_addr = addr_locked ? my_addr : strap_addr;
  function automatic logic [7:0] rd_reg(input logic [7:0] a);
    unique case (a)
      `SSP_REG_START:   rd_reg = start_reg;
      `SSP_REG_SPECIAL: rd_reg = special_reg;
      `SSP_REG_STATUS:  rd_reg = status_o;
      default:          rd_reg = 8'h00; // R10
    endcase
  endfunction : rd_reg
  wire [7:0] rd_val = rd_reg(reg_ptr);
  // timeout on clock low
  always_ff @(posedge clk_i) begin
    if (rst_i || scl_f || st == ssp_pkg::SSP_IDLE) to_cnt <= '0;
    else if (!timeout) to_cnt <= to_cnt + 22'd1;
  end
  assign timeout = (to_cnt >= 22'(TO_CYC - 1)); // R12
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= ssp_pkg::SSP_IDLE;
      sh <= 8'h00;
      bitc <= 3'h0;
      byten <= 2'h0;
      rd <= 1'b0;
      ara <= 1'b0;
      had_reg <= 1'b0;
      fresh <= 1'b0;
      reg_ptr <= 8'h00;
      wdata <= 8'h00;
      bus.sda_dev_o <= 1'b0;
      bus.sda_dev_oe_n <= 1'b1; // R13
    end else if (timeout) begin
      st <= ssp_pkg::SSP_IDLE; // R12
      bus.sda_dev_oe_n <= 1'b1;
    end else if (start_c) begin
      st <= ssp_pkg::SSP_ADDR;
      rd <= 1'b0;
      had_reg <= (st != ssp_pkg::SSP_IDLE) && byten == 2'h2; // R5
      // a stale byte count would let a foreign-address stop commit
      byten <= 2'h0; // R6
      bitc <= 3'h0;
      fresh <= 1'b1;
      bus.sda_dev_oe_n <= 1'b1;
    end else if (stop_c) begin
      st <= ssp_pkg::SSP_IDLE; // R14
      bus.sda_dev_oe_n <= 1'b1;
    end else begin
      unique case (st)
        ssp_pkg::SSP_IDLE, ssp_pkg::SSP_SKIP: bus.sda_dev_oe_n <= 1'b1; // R7
        ssp_pkg::SSP_ADDR, ssp_pkg::SSP_RX: begin
          if (scl_rise) begin
            sh <= {sh[6:0], sda_f}; // R2
            bitc <= bitc + 3'h1;
            fresh <= 1'b0;
          end
          if (scl_fall && !fresh && bitc == 3'h0) begin
            if (st == ssp_pkg::SSP_ADDR) begin
              rd <= sh[0];
              ara <= sh[7:1] == `SSP_ADDR_ARA;
              if (sh[7:1] == `SSP_ADDR_ARA && sh[0] && alert_on && !had_reg) begin
                st <= ssp_pkg::SSP_AACK; // R15
                bus.sda_dev_oe_n <= 1'b0;
              end else if (sh[7:1] != `SSP_ADDR_GCALL && sh[7:1] == cur_addr &&
                           (sh[0] == had_reg)) begin // R11
                st <= ssp_pkg::SSP_AACK;
                bus.sda_dev_oe_n <= 1'b0;
                byten <= sh[0] ? 2'h3 : 2'h1;
              end else begin
                st <= ssp_pkg::SSP_SKIP; // R7
              end
            end else begin
              st <= ssp_pkg::SSP_RACK;
              bus.sda_dev_oe_n <= 1'b0;
              if (byten == 2'h1) reg_ptr <= sh; // R1
              else wdata <= sh;
            end
          end
        end
        ssp_pkg::SSP_AACK, ssp_pkg::SSP_RACK: begin
          if (scl_fall) begin
            if (rd) begin
              sh <= ara ? {cur_addr, 1'b1} : rd_val; // R16
              st <= ssp_pkg::SSP_TX; // R4
            end else begin
              st <= (st == ssp_pkg::SSP_RACK && byten == 2'h2) ?
                    ssp_pkg::SSP_SKIP : ssp_pkg::SSP_RX;
              if (st == ssp_pkg::SSP_RACK) byten <= byten + 2'h1; // R3
            end
            bus.sda_dev_oe_n <= 1'b1;
            bitc <= 3'h0;
            if (rd) begin
              bus.sda_dev_oe_n <= ara ? cur_addr[6] : rd_val[7];
            end
          end
        end
        ssp_pkg::SSP_TX: begin
          if (scl_fall) begin
            bitc <= bitc + 3'h1;
            sh <= {sh[6:0], 1'b1};
            bus.sda_dev_oe_n <= (bitc == 3'h7) ? 1'b1 : sh[6]; // R2
            if (bitc == 3'h7) st <= ssp_pkg::SSP_TACK;
          end
        end
        ssp_pkg::SSP_TACK: begin
          if (scl_rise) st <= ssp_pkg::SSP_SKIP; // R23
        end
        default: st <= ssp_pkg::SSP_IDLE;
      endcase
    end
  end
  // write commit at the stop of a complete write, alert answer strobe
  logic commit, ara_done;
  always_ff @(posedge clk_i) begin
    if (rst_i) commit <= 1'b0;
    else commit <= stop_c && !rd && byten == 2'h3 && st == ssp_pkg::SSP_SKIP; // R6
  end
  assign ara_done = (st == ssp_pkg::SSP_AACK) && scl_fall && ara;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      start_reg <= `SSP_START_RESET; // R21
      special_reg <= `SSP_SPECIAL_RESET;
    end else begin
      if (commit && reg_ptr == `SSP_REG_START) start_reg <= wdata; // R20
      if (commit && reg_ptr == `SSP_REG_SPECIAL) special_reg <= wdata;
      if (ara_done) special_reg[`SSP_ALERT_IRQ_ENABLE_BIT] <= 1'b0; // R17
    end
  end
  // status: set wins over a clearing write of ones
  always_ff @(posedge clk_i) begin
    if (rst_i) status_o <= 8'h00;
    else status_o <= (status_o & ~((commit && reg_ptr == `SSP_REG_STATUS) ? wdata : 8'h00))
                     | event_i; // R22
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      my_addr <= `SSP_ADDR_DEFAULT;
      addr_locked <= 1'b0;
    end else if (!addr_locked && commit && !aen_s[1]) begin
      my_addr <= strap_addr; // R9
      addr_locked <= 1'b1;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      monitor_start_o <= 1'b0;
      bus.alert_n_oe_n <= 1'b1;
      fan_drive2_pin_oe_n_o <= 1'b1;
      fan_speed_in3_pin_oe_n_o <= 1'b1;
    end else begin
      monitor_start_o <= start_reg[`SSP_START_BIT];
      bus.alert_n_oe_n <= ~alert_on;
      fan_drive2_pin_oe_n_o <= ~(alert_on & alert_route_i[0]); // R19
      fan_speed_in3_pin_oe_n_o <= ~(alert_on & alert_route_i[1]);
    end
  end
endmodule : ssp_dev

// *** rtl/ssp_host.sv ***
// smbus host controller driven from classic wishbone
`include "ssp_map.svh"
`timescale 1ns/1ps
module ssp_host (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  ssp_if.host              bus,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o
);
  localparam int HALF = `SSP_HALF_CYC;
  // cmd: [6:0] addr, [15:8] reg, [16] read, [17] ara
  logic [17:0] cmd;
  logic [7:0]  wdata, rdata;
  logic        busy, nack_seen, alert_q, alert_s;
  logic [7:0]  tick_cnt;
  logic        tick;
  ssp_pkg::ssp_host_t st;
  logic [1:0]  phase;
  logic [3:0]  bitn;
  logic [2:0]  byten;
  logic [8:0]  sh;
  logic [1:0]  sda_s;
  wire go = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o &&
            wb_adr_i == `SSP_WB_CMD && !busy;
  always_ff @(posedge clk_i) begin
    if (rst_i) wb_ack_o <= 1'b0;
    else wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) wb_dat_o <= 32'h0;
    else if (wb_adr_i == `SSP_WB_STATUS)
      wb_dat_o <= {21'h0, alert_s, nack_seen, busy, rdata};
    else wb_dat_o <= 32'h0;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) wdata <= 8'h00;
    else if (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o &&
             wb_adr_i == `SSP_WB_WDATA && wb_sel_i[0]) wdata <= wb_dat_i[7:0];
  end
  always_ff @(posedge clk_i) begin
    sda_s <= {sda_s[0], bus.sda};
    alert_q <= ~bus.alert_n_oe_n;
    alert_s <= alert_q;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i || !busy) tick_cnt <= 8'h00;
    else tick_cnt <= tick ? 8'h00 : tick_cnt + 8'h01;
  end
  assign tick = tick_cnt == 8'(HALF - 1);
  // byte n: 0 addr-wr / ara-rd, 1 reg, 2 data or addr-rd, 3 read data
  function automatic logic [8:0] byte_of(input logic [2:0] n);
    unique case (n)
      3'h0: byte_of = cmd[17] ? {7'h0c, 1'b1, 1'b1} : {cmd[6:0], 1'b0, 1'b1};
      3'h1: byte_of = {cmd[15:8], 1'b1};
      3'h2: byte_of = cmd[16] ? {cmd[6:0], 1'b1, 1'b1} : {wdata, 1'b1};
      default: byte_of = 9'h1ff; // R4
    endcase
  endfunction : byte_of
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy <= 1'b0;
      cmd <= 18'h0;
      st <= ssp_pkg::SSP_H_IDLE;
      phase <= 2'h0;
      bitn <= 4'h0;
      byten <= 3'h0;
      sh <= 9'h1ff;
      rdata <= 8'h00;
      nack_seen <= 1'b0;
      bus.scl_o <= 1'b0;
      bus.scl_oe_n <= 1'b1;
      bus.sda_host_o <= 1'b0;
      bus.sda_host_oe_n <= 1'b1;
    end else if (go) begin
      busy <= 1'b1;
      cmd <= wb_dat_i[17:0];
      nack_seen <= 1'b0;
      st <= ssp_pkg::SSP_H_START;
      phase <= 2'h0;
    end else if (busy && tick) begin
      phase <= phase + 2'h1;
      unique case (st)
        ssp_pkg::SSP_H_IDLE: busy <= 1'b0;
        ssp_pkg::SSP_H_START, ssp_pkg::SSP_H_RSTA: begin
          if (phase == 2'h0) begin
            bus.sda_host_oe_n <= 1'b1;
            bus.scl_oe_n <= 1'b1;
          end
          if (phase == 2'h1) bus.sda_host_oe_n <= 1'b0;
          if (phase == 2'h2) begin
            bus.scl_oe_n <= 1'b0;
            sh <= byte_of(st == ssp_pkg::SSP_H_RSTA ? 3'h2 : 3'h0);
            byten <= (st == ssp_pkg::SSP_H_RSTA) ? 3'h2 : 3'h0;
            bitn <= 4'h0;
            st <= ssp_pkg::SSP_H_BIT;
            phase <= 2'h0;
          end
        end
        ssp_pkg::SSP_H_BIT: begin
          if (phase == 2'h0) bus.sda_host_oe_n <= sh[8];
          if (phase == 2'h1) bus.scl_oe_n <= 1'b1;
          if (phase == 2'h2) begin
            if (bitn < 4'h8 && byten == 3'h3) rdata <= {rdata[6:0], sda_s[1]};
            if (bitn == 4'h8 && byten != 3'h3 && sda_s[1]) nack_seen <= 1'b1;
            bus.scl_oe_n <= 1'b0;
            sh <= {sh[7:0], 1'b1}; // R2
            bitn <= bitn + 4'h1;
            phase <= 2'h0;
            if (bitn == 4'h8) begin
              bitn <= 4'h0;
              if (byten == 3'h3 || (byten == 3'h2 && !cmd[16]) || sda_s[1])
                st <= ssp_pkg::SSP_H_STOP; // R3
              else if (byten == 3'h1 && cmd[16]) st <= ssp_pkg::SSP_H_RSTA; // R4
              else if (byten == 3'h0 && cmd[17]) begin
                byten <= 3'h3;
                sh <= byte_of(3'h3);
              end else begin
                byten <= byten + 3'h1;
                sh <= byte_of(byten + 3'h1 == 3'h2 && cmd[16] ? 3'h3 : byten + 3'h1);
              end
            end
          end
        end
        ssp_pkg::SSP_H_STOP: begin
          if (phase == 2'h0) bus.sda_host_oe_n <= 1'b0;
          if (phase == 2'h1) bus.scl_oe_n <= 1'b1;
          if (phase == 2'h2) begin
            bus.sda_host_oe_n <= 1'b1;
            st <= ssp_pkg::SSP_H_IDLE;
          end
        end
        default: st <= ssp_pkg::SSP_H_IDLE;
      endcase
    end
  end
endmodule : ssp_host

// *** rtl/ssp_if.sv ***
// smbus wires joining the register port and its host controller
`timescale 1ns/1ps
interface ssp_if;
  logic scl_o;
  logic scl_oe_n;
  logic sda_host_o;
  logic sda_host_oe_n;
  logic sda_dev_o;
  logic sda_dev_oe_n;
  logic alert_n_oe_n;
  // open drain: a low enable pulls the wire low, otherwise pulled up
  logic scl;
  logic sda;
  assign scl = scl_oe_n ? 1'b1 : scl_o;
  assign sda = (sda_host_oe_n ? 1'b1 : sda_host_o) & (sda_dev_oe_n ? 1'b1 : sda_dev_o);
  modport dev  (input scl, input sda, output sda_dev_o, output sda_dev_oe_n,
                output alert_n_oe_n);
  modport host (input scl, input sda, output scl_o, output scl_oe_n,
                output sda_host_o, output sda_host_oe_n, input alert_n_oe_n);
endinterface : ssp_if

// *** rtl/ssp_map.svh ***
// constants for the smbus slave register port
`ifndef SSP_MAP_SVH
`define SSP_MAP_SVH
`define SSP_ADDR_DEFAULT   7'h2e
`define SSP_ADDR_SEL0      7'h2c
`define SSP_ADDR_SEL1      7'h2d
`define SSP_ADDR_ARA       7'h0c
`define SSP_ADDR_GCALL     7'h00
`define SSP_REG_START      8'h40
`define SSP_REG_SPECIAL    8'h7c
`define SSP_REG_STATUS     8'h41
`define SSP_START_BIT      0
`define SSP_ALERT_IRQ_ENABLE_BIT      2
`define SSP_START_RESET    8'h00
`define SSP_SPECIAL_RESET  8'h40
`define SSP_CLK_MHZ        100
`define SSP_TIMEOUT_MS     25
`define SSP_TIMEOUT_CYC    (`SSP_TIMEOUT_MS * 1000 * `SSP_CLK_MHZ)
`define SSP_HALF_NS        2500
`define SSP_HALF_CYC       (`SSP_HALF_NS * `SSP_CLK_MHZ / 1000)
`define SSP_WB_CMD         4'h0
`define SSP_WB_WDATA       4'h4
`define SSP_WB_STATUS      4'h8
`endif

// *** rtl/ssp_pkg.sv ***
// types shared by both ends of the smbus slave register port
package ssp_pkg;
  typedef enum logic [3:0] {
    SSP_IDLE  = 4'h0,
    SSP_ADDR  = 4'h1,
    SSP_AACK  = 4'h2,
    SSP_RX    = 4'h3,
    SSP_RACK  = 4'h4,
    SSP_TX    = 4'h5,
    SSP_TACK  = 4'h6,
    SSP_SKIP  = 4'h7
  } ssp_slv_t;
  typedef enum logic [2:0] {
    SSP_H_IDLE  = 3'h0,
    SSP_H_START = 3'h1,
    SSP_H_BIT   = 3'h2,
    SSP_H_STOP  = 3'h3,
    SSP_H_RSTA  = 3'h4
  } ssp_host_t;
endpackage : ssp_pkg

// *** tb/ssp_props.sv ***
// wire-level assertions on the smbus joining the port and its host
`timescale 1ns/1ps
`include "ssp_map.svh"
module ssp_props (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic scl,
  input wire logic sda,
  input wire logic scl_oe_n,
  input wire logic sda_host_oe_n,
  input wire logic sda_dev_oe_n,
  input wire logic alert_n_oe_n
);
  localparam int TMO = `SSP_TIMEOUT_CYC;
  localparam int DRV_MAX = 8000;
  logic [21:0] low_cnt;
  logic [12:0] drv_cnt;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // clock-low run length, compared against the bus timeout
  always_ff @(posedge clk_i) begin
    if (rst_i || scl) low_cnt <= '0;
    else low_cnt <= low_cnt + 22'h1;
  end

  // ack plus eight zero bits is the longest legal device drive
  always_ff @(posedge clk_i) begin
    if (rst_i || sda_dev_oe_n) drv_cnt <= '0;
    else drv_cnt <= drv_cnt + 13'h1;
  end

  sequence start_s;
    scl && $past(scl) && $fell(sda);
  endsequence
  sequence stop_s;
    scl && $past(scl) && $rose(sda);
  endsequence

  AST_START_RELEASED: assert property (start_s |-> sda_dev_oe_n)
    else $error("device drives data at a start");
  AST_STOP_IDLE: assert property (stop_s |-> ##1 sda_dev_oe_n [*8])
    else $error("device drives data after a stop");
  AST_DEV_HOLD_HIGH: assert property (scl && $past(scl) |-> $stable(sda_dev_oe_n))
    else $error("device data changed while clock high");
  AST_DEV_NO_CLOCK: assert property (!scl |-> !scl_oe_n)
    else $error("clock low without host drive");
  AST_LOW_TIMEOUT: assert property (low_cnt < TMO)
    else $error("clock held low past timeout");
  AST_DRIVE_BOUNDED: assert property (drv_cnt < DRV_MAX)
    else $error("device holds data line too long");
  AST_DRIVE_CLOCKED: assert property ($fell(sda_dev_oe_n) |-> ##[1:1000] scl)
    else $error("device drive not clocked by host");
  AST_HOST_YIELDS: assert property (!sda_dev_oe_n && scl |-> sda_host_oe_n)
    else $error("host drives data during device bit");
  AST_ALERT_IDLE_RST: assert property ($fell(rst_i) |-> alert_n_oe_n)
    else $error("alert asserted out of reset");
endmodule : ssp_props

// *** tb/tb.sv ***
// self-checking bench: wishbone host controller driving the smbus port
`include "ssp_map.svh"
`timescale 1ns/1ps
module tb;
  logic        clk_i          = 1'b0;
  logic        rst_i          = 1'b1;
  logic        wb_cyc_i       = 1'b0;
  logic        wb_stb_i       = 1'b0;
  logic        wb_we_i        = 1'b0;
  logic [3:0]  wb_adr_i       = 4'h0;
  logic [3:0]  wb_sel_i       = 4'h1;
  logic [31:0] wb_dat_i       = 32'h0;
  logic [7:0]  event_i        = 8'h00;
  logic [7:0]  group_enable_i = 8'h00;
  logic [1:0]  alert_route_i  = 2'h0;
  logic        addr_enable_n  = 1'b1;
  logic        addr_select    = 1'b0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        monitor_start_o;
  logic [7:0]  status_o;
  logic        fd2_oe_n;
  logic        fs3_oe_n;
  logic [31:0] q;
  int          err_total = 0;
  int          n_tests   = 0;
  int          cyc_cnt   = 0;

  ssp_if i_ssp_if ();
  ssp_dev i_ssp_dev (.clk_i(clk_i), .rst_i(rst_i), .bus(i_ssp_if.dev),
    .addr_enable_n_i(addr_enable_n), .addr_select_i(addr_select), .event_i(event_i),
    .group_enable_i(group_enable_i), .alert_route_i(alert_route_i),
    .monitor_start_o(monitor_start_o), .status_o(status_o),
    .fan_drive2_pin_oe_n_o(fd2_oe_n), .fan_speed_in3_pin_oe_n_o(fs3_oe_n));
  ssp_host i_ssp_host (.clk_i(clk_i), .rst_i(rst_i), .bus(i_ssp_if.host),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
  ssp_props i_ssp_props (.clk_i(clk_i), .rst_i(rst_i), .scl(i_ssp_if.scl),
    .sda(i_ssp_if.sda), .scl_oe_n(i_ssp_if.scl_oe_n),
    .sda_host_oe_n(i_ssp_if.sda_host_oe_n), .sda_dev_oe_n(i_ssp_if.sda_dev_oe_n),
    .alert_n_oe_n(i_ssp_if.alert_n_oe_n));

  always #5 clk_i = ~clk_i;

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : wrap_up

  // the whole sequence needs about 100k cycles, one read about 30k
  always @(posedge clk_i) begin
    cyc_cnt++;
    if (cyc_cnt == 120000) begin
      err_total++;
      $display("[FAIL] timeout expected end seen hang");
      wrap_up();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  function automatic logic [31:0] cmdw(input logic ara, input logic rd,
                                        input logic [7:0] rg, input logic [6:0] ad);
    return {14'h0, ara, rd, rg, 1'b0, ad};
  endfunction : cmdw

  task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] dat);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
    // ack must stand for one cycle only
    chk("wb ack drop", 32'h0, {31'h0, wb_ack_o});
  endtask : wb

  // polling keeps the master honest: no assumed transfer length
  task automatic smb(input logic [31:0] wdata, input logic [31:0] cmd);
    wb(1'b1, `SSP_WB_WDATA, wdata);
    wb(1'b1, `SSP_WB_CMD, cmd);
    do begin
      wb(1'b0, `SSP_WB_STATUS, 32'h0);
    end while (q[8] !== 1'b0);
  endtask : smb

  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk("start after reset", 32'h0, {31'h0, monitor_start_o});
    chk("alert after reset", 32'h1, {31'h0, i_ssp_if.alert_n_oe_n});
    smb(32'h01, cmdw(1'b0, 1'b0, `SSP_REG_START, `SSP_ADDR_DEFAULT));
    chk("write nack", 32'h0, {31'h0, q[9]});
    chk("monitor start", 32'h1, {31'h0, monitor_start_o});
    smb(32'h00, cmdw(1'b0, 1'b1, `SSP_REG_SPECIAL, `SSP_ADDR_DEFAULT));
    chk("special read", {24'h0, `SSP_SPECIAL_RESET}, {24'h0, q[7:0]});
    smb(32'h00, cmdw(1'b0, 1'b0, `SSP_REG_START, `SSP_ADDR_GCALL));
    chk("gcall nack", 32'h1, {31'h0, q[9]});
    chk("start kept", 32'h1, {31'h0, monitor_start_o});
    event_i        <= 8'h01;
    group_enable_i <= 8'h01;
    alert_route_i  <= 2'h1;
    addr_enable_n  <= 1'b0;
    addr_select    <= 1'b1;
    repeat (20) @(posedge clk_i);
    chk("status event", 32'h1, {31'h0, status_o[0]});
    chk("alert masked", 32'h1, {31'h0, i_ssp_if.alert_n_oe_n});
    smb(32'h44, cmdw(1'b0, 1'b0, `SSP_REG_SPECIAL, `SSP_ADDR_SEL1));
    chk("strap write nack", 32'h0, {31'h0, q[9]});
    // moving the strap after the first write made with address enable low must not move the address
    addr_select    <= 1'b0;
    for (int i = 0; i < 1000 && i_ssp_if.alert_n_oe_n !== 1'b0; i++) @(posedge clk_i);
    chk("alert raised", 32'h0, {31'h0, i_ssp_if.alert_n_oe_n});
    chk("alert pin", 32'h0, {31'h0, fd2_oe_n});
    chk("alert pin unrouted", 32'h1, {31'h0, fs3_oe_n});
    wb(1'b0, `SSP_WB_STATUS, 32'h0);
    chk("alert status", 32'h1, {31'h0, q[10]});
    smb(32'h00, cmdw(1'b1, 1'b1, 8'h00, `SSP_ADDR_ARA));
    chk("alert answer", {25'h0, `SSP_ADDR_SEL1}, {25'h0, q[7:1]});
    chk("alert released", 32'h1, {31'h0, i_ssp_if.alert_n_oe_n});
    chk("alert status clear", 32'h0, {31'h0, q[10]});
    wrap_up();
  end
endmodule : tb
